//--- tb/brasc_rom_model.sv
// byte-wide boot rom and flash model
`timescale 1ns/1ns
module brasc_rom_model (
    input wire logic [15:0] addr,
    input wire logic [7:0] din,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [7:0] dout
);
    logic [7:0] mem [65536];
    logic [7:0] last = 8'h00;
    // ========
    // array and read path
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end
    always @(addr, ce_n, oe_n) if (!ce_n && !oe_n) last = mem[addr];
    // released bus shows the inverted last byte
    always @* dout = (!ce_n && !oe_n) ? mem[addr] : ~last;
    // byte lands as the write strobe ends
    always @(posedge we_n) if (!ce_n) mem[addr] = din;
endmodule

//--- tb/brasc_top_chk.sv
// assertion checker for the boot rom and strap block
`timescale 1ns/1ns
module brasc_top_chk #(
    parameter int ACC_CYC = 12
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic HOST_REQ,
    input wire logic HOST_ACK,
    input wire logic [15:0] ROM_ADDR,
    input wire logic [7:0] ROM_DATA_I,
    input wire logic ROM_DATA_OE,
    input wire logic ROM_CE_N,
    input wire logic ROM_OE_N,
    input wire logic ROM_WE_N,
    input wire logic [7:0] VIDEO_PORT_O,
    input wire logic [7:0] TV_OUT_O,
    input wire logic [11:0] STRAP_PINS_I,
    input wire logic PLL_BYPASS,
    input wire logic MEM_SDRAM,
    input wire logic MEM_SHORT_PON,
    input wire logic IDSEL_REMAP,
    input wire logic IRQ_REG_DISABLE,
    input wire logic MEM_16MB_PARTS,
    input wire logic MEM_EIGHT_PARTS,
    input wire logic CLASS_MULTIMEDIA,
    input wire logic AGP_ENABLE,
    input wire logic BUS_66MHZ,
    input wire logic ROM_64K,
    input wire logic FAST_DEVSEL
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    wire logic [11:0] strap_w = {PLL_BYPASS, MEM_SDRAM, MEM_SHORT_PON, IDSEL_REMAP, IRQ_REG_DISABLE,
        MEM_16MB_PARTS, MEM_EIGHT_PARTS, CLASS_MULTIMEDIA, AGP_ENABLE, BUS_66MHZ, ROM_64K, FAST_DEVSEL};
    logic [1:0] rel_cnt_ff;
    logic [11:0] cap_ff;
    int lo_cnt_ff;
    // ========
    // helper state
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rel_cnt_ff <= 2'h0;
        end else if (rel_cnt_ff != 2'h2) begin
            rel_cnt_ff <= rel_cnt_ff + 2'h1;
        end
    end
    always_ff @(posedge CLK) begin
        if (RESETN && rel_cnt_ff == 2'h0) begin
            cap_ff <= STRAP_PINS_I;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESETN || ROM_CE_N) begin
            lo_cnt_ff <= 0;
        end else begin
            lo_cnt_ff <= lo_cnt_ff + 1;
        end
    end
    // ========
    // assertions
    AST_STRAP_HOLD: assert property (rel_cnt_ff == 2'h2 |-> strap_w == cap_ff)
        else $error("strap word moved");
    AST_ROM_32K: assert property (rel_cnt_ff == 2'h2 && !ROM_CE_N && !cap_ff[1] |-> !ROM_ADDR[15])
        else $error("32K rom addressed high");
    AST_ACK_PULSE: assert property (HOST_ACK |=> !HOST_ACK)
        else $error("ack too long");
    AST_ACK_REQ: assert property (HOST_ACK |-> HOST_REQ && $past(HOST_REQ))
        else $error("ack without request");
    AST_WE_DRIVE: assert property (!ROM_WE_N |-> !ROM_CE_N && ROM_DATA_OE && ROM_OE_N)
        else $error("write strobe undriven");
    AST_NO_FIGHT: assert property (!ROM_OE_N |-> !ROM_DATA_OE && ROM_WE_N)
        else $error("data bus fight");
    AST_VIDEO_SHARE: assert property (!ROM_CE_N && !ROM_OE_N && $past(!ROM_CE_N && !ROM_OE_N)
        |-> VIDEO_PORT_O == $past(ROM_DATA_I) && TV_OUT_O == $past(ROM_DATA_I))
        else $error("video not rom byte");
    AST_CE_LEN: assert property ($rose(ROM_CE_N) |-> lo_cnt_ff == ACC_CYC)
        else $error("bad byte cycle length");
endmodule
bind brasc_top brasc_top_chk #(.ACC_CYC(ACC_CYC)) u_chk (.*);

//--- tb/tb_brasc_top.sv
// self-checking bench for the boot rom and strap block
`timescale 1ns/1ns
module tb_brasc_top;
    localparam int ACC = 3;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, HOST_REQ = 1'b0, HOST_WR = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, VIDEO_PIXEL_I = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000, HOST_ADDR = 32'h0000_0000, HOST_WDATA = 32'h0000_0000;
    logic [3:0] S_AXI_WSTRB = 4'hf, HOST_BE = 4'h0;
    logic [11:0] STRAP_PINS_I = 12'h000;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, HOST_HIT, HOST_ACK;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
    logic [31:0] S_AXI_RDATA, HOST_RDATA, SUBSYS_ID, rd, wb, a;
    logic [15:0] ROM_ADDR, msk;
    logic [7:0] ROM_DATA_O, VIDEO_PORT_O, TV_OUT_O, rom_q, dv;
    logic ROM_DATA_OE, ROM_CE_N, ROM_OE_N, ROM_WE_N, ack, hit;
    logic PLL_BYPASS, MEM_SDRAM, MEM_SHORT_PON, IDSEL_REMAP, IRQ_REG_DISABLE, MEM_16MB_PARTS;
    logic MEM_EIGHT_PARTS, CLASS_MULTIMEDIA, AGP_ENABLE, BUS_66MHZ, ROM_64K, FAST_DEVSEL;
    logic [11:0] straps;
    logic [3:0] be;
    int err_count = 0;
    int cmp_count = 0;
    int lat, base_lat, nb;
    wire logic [7:0] ROM_DATA_I = ROM_DATA_OE ? ROM_DATA_O : rom_q;
    wire logic [11:0] strap_o = {PLL_BYPASS, MEM_SDRAM, MEM_SHORT_PON, IDSEL_REMAP, IRQ_REG_DISABLE,
        MEM_16MB_PARTS, MEM_EIGHT_PARTS, CLASS_MULTIMEDIA, AGP_ENABLE, BUS_66MHZ, ROM_64K, FAST_DEVSEL};
    brasc_top #(.ACC_CYC(ACC)) dut (.*);
    brasc_rom_model rom (.addr(ROM_ADDR), .din(ROM_DATA_O), .ce_n(ROM_CE_N), .oe_n(ROM_OE_N),
        .we_n(ROM_WE_N), .dout(rom_q));
    always #5 CLK = ~CLK;
    // ========
    // expectations
    function automatic logic [7:0] rb(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction
    function automatic logic [31:0] exp_rd(input logic [31:0] x, input logic [3:0] e);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (e[i]) v[8*i+:8] = rb({x[15:2], 2'(i)} & msk);
        end
        return v;
    endfunction
    // ========
    // checking and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        $display("mismatch at %0t: wait ran out", $time);
        final_report();
    endtask
    // ========
    // bus drivers
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge CLK);
        S_AXI_AWADDR <= ad;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        resp = 2'h3;
        for (int n = 0; n < 50 && resp === 2'h3; n++) begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID) begin
                resp = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
            end
        end
        if (resp === 2'h3) tmo();
    endtask
    task automatic axi_rd(input logic [7:0] ad);
        @(posedge CLK);
        S_AXI_ARADDR <= ad;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        resp = 2'h3;
        for (int n = 0; n < 50 && resp === 2'h3; n++) begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID) begin
                resp = S_AXI_RRESP;
                rd = S_AXI_RDATA;
                S_AXI_RREADY <= 1'b0;
            end
        end
        if (resp === 2'h3) tmo();
    endtask
    // refused requests run out the window
    task automatic host(input logic w, input logic [31:0] ad, input logic [3:0] e, input logic [31:0] d);
        HOST_WR <= w;
        HOST_ADDR <= ad;
        HOST_BE <= e;
        HOST_WDATA <= d;
        HOST_REQ <= 1'b1;
        ack = 1'b0;
        for (lat = 0; lat < 80 && ack !== 1'b1; lat++) begin
            @(posedge CLK);
            if (lat == 0) hit = HOST_HIT;
            ack = HOST_ACK;
        end
        HOST_REQ <= 1'b0;
        @(posedge CLK);
    endtask
    // ========
    // main sequence, one pass per rom size
    initial begin
        void'($urandom(32'h0000_94e4));
        for (int p = 0; p < 2; p++) begin
            straps = 12'($urandom);
            straps[1] = p[0];
            msk = p[0] ? 16'hffff : 16'h7fff;
            @(posedge CLK);
            STRAP_PINS_I <= straps;
            VIDEO_PIXEL_I <= 8'($urandom);
            RESETN <= 1'b0;
            repeat (16) @(posedge CLK);
            RESETN <= 1'b1;
            rd = 32'h0000_0000;
            for (int n = 0; n < 40 && rd[brasc_pkg::STATUS_LOADED] !== 1'b1; n++) axi_rd(brasc_pkg::ADDR_STATUS);
            if (rd[brasc_pkg::STATUS_LOADED] !== 1'b1) tmo();
            STRAP_PINS_I <= ~straps;
            check(32'(strap_o), 32'(straps));
            axi_wr(brasc_pkg::ADDR_STRAP, 32'hffff_ffff);
            check(32'(resp), 32'(brasc_pkg::RESP_SLVERR));
            axi_rd(brasc_pkg::ADDR_STRAP);
            check(rd, 32'(straps));
            $display("test straps done");
            a = 32'(msk - 16'h0007);
            check(SUBSYS_ID, exp_rd(a, 4'hf));
            axi_rd(brasc_pkg::ADDR_SUBSYS);
            check(rd, exp_rd(a, 4'hf));
            axi_rd(brasc_pkg::ADDR_ROM_BASE);
            check(rd, brasc_pkg::ROM_BASE_RST);
            axi_rd(brasc_pkg::ADDR_MISC);
            check(rd, brasc_pkg::MISC_RST);
            axi_rd(8'hf0);
            check(32'(resp), 32'(brasc_pkg::RESP_SLVERR));
            $display("test ids done");
            wb = {16'($urandom), 16'h0000};
            host(1'b0, wb | 32'h0000_0100, 4'hf, 32'h0000_0000);
            check(32'({ack, hit}), 32'h0000_0000);
            axi_wr(brasc_pkg::ADDR_ROM_BASE, wb | 32'h0000_0001);
            axi_rd(brasc_pkg::ADDR_ROM_BASE);
            check(rd, wb | 32'h0000_0001);
            host(1'b0, wb ^ 32'h8000_0100, 4'hf, 32'h0000_0000);
            check(32'({ack, hit}), 32'h0000_0000);
            VIDEO_PIXEL_I <= 8'h00;
            for (int k = 0; k < 8; k++) begin
                a = wb | 32'($urandom & msk) | 32'h0000_0100;
                be = (k == 0) ? 4'h1 : 4'($urandom);
                nb = $countones(be);
                host(1'b0, a, be, 32'h0000_0000);
                if (k == 0) base_lat = lat;
                check(32'({ack, hit}), 32'h0000_0003);
                check(HOST_RDATA, exp_rd(a, be));
                check(lat - base_lat, (nb - 1) * (ACC + 1));
            end
            $display("test reads done");
            host(1'b1, wb | 32'h0000_0020, 4'h1, 32'h0000_00a5);
            check(32'({ack, hit}), 32'h0000_0000);
            axi_wr(brasc_pkg::ADDR_MISC, 32'h0000_0010);
            check(32'(resp), 32'(brasc_pkg::RESP_OKAY));
            // mode writes restore stored bytes, keeping the image known
            host(1'b1, wb | 32'h0000_0aa8, 4'h1, {24'h00_0000, rb(16'h0aa8)});
            host(1'b1, wb | 32'h0000_0aa8, 4'h2, {16'h0000, rb(16'h0aa9), 8'h00});
            dv = 8'($urandom);
            host(1'b1, wb | 32'h0000_0020, 4'h1, {24'h00_0000, dv});
            check(32'({ack, hit}), 32'h0000_0003);
            host(1'b0, wb | 32'h0000_0020, 4'h1, 32'h0000_0000);
            check(HOST_RDATA, {24'h00_0000, dv});
            $display("test flash done");
        end
        final_report();
    end
endmodule

//--- verilog/brasc_pkg.sv
// constants and types of the boot rom and strap block
package brasc_pkg;
    // ==========
    // register byte addresses
    localparam logic [7:0] ADDR_ROM_BASE = 8'h00;
    localparam logic [7:0] ADDR_MISC = 8'h04;
    localparam logic [7:0] ADDR_STRAP = 8'h08;
    localparam logic [7:0] ADDR_SUBSYS = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // ==========
    // field positions
    localparam int ROM_EN_BIT = 0;
    localparam int ROM_WR_EN_BIT = 4;
    localparam int BASE_LSB_32K = 15;
    localparam int BASE_LSB_64K = 16;
    localparam int STRAP_PLL_BYPASS = 11;
    localparam int STRAP_SDRAM = 10;
    localparam int STRAP_SHORT_PON = 9;
    localparam int STRAP_IDSEL_REMAP = 8;
    localparam int STRAP_IRQ_DIS = 7;
    localparam int STRAP_DENSITY = 6;
    localparam int STRAP_EIGHT_PARTS = 5;
    localparam int STRAP_MULTIMEDIA = 4;
    localparam int STRAP_AGP_EN = 3;
    localparam int STRAP_66MHZ = 2;
    localparam int STRAP_ROM_64K = 1;
    localparam int STRAP_FAST_DEVSEL = 0;
    localparam int STATUS_LOADED = 0;
    localparam int STATUS_ACTIVE = 1;
    // ==========
    // reset values and sizes
    localparam logic [31:0] ROM_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] MISC_RST = 32'h0000_0000;
    localparam logic [11:0] STRAP_RST = 12'h000;
    localparam logic [15:0] ID_OFS_32K = 16'h7FF8;
    localparam logic [15:0] ID_OFS_64K = 16'hFFF8;
    localparam logic [31:0] BASE_MASK_32K = 32'hFFFF_8001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ROM_ACCESS_NS = 120;
    localparam int ROM_ACC_CYC = (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========
    // sequencer states
    typedef enum logic [4:0] {
        ST_CAPT = 5'b0_0001,
        ST_PICK = 5'b0_0010,
        ST_CYC = 5'b0_0100,
        ST_IDLE = 5'b0_1000,
        ST_ACK = 5'b1_0000
    } brasc_state_t;
endpackage

//--- verilog/brasc_top.sv
// boot rom window, id load, strap capture and registers
// Contract
// (R1) rom is 32K or 64K, size set by strap
// (R2) ids loaded after reset from four bytes before the last four
// (R3) last four bytes are checksum, never ids
// (R4) reads decoded only with base bit 0 set and upper bits matching
// (R5) any byte enables; bytes fetched one at a time
// (R6) video port and tv show rom bus during access
// (R7) software blanks video port and tv first
// (R8) writes only with base bit 0 and misc bit 4
// (R9) flash: mode writes, data writes, polling reads
// (R10) twelve straps caught at power-up, bit 11 highest
// (R11) bit 11 bypasses clock synthesizer
// (R12) bit 10: sdram, else sgram
// (R13) bit 9: short memory power-on
// (R14) bit 8: ad line 16 as idsel
// (R15) bit 7: interrupt register off
// (R16) bit 6: 16Mb parts, else 8Mb
// (R17) bit 5: eight parts, else four
// (R18) bit 4: multimedia class, else vga
// (R19) bit 3: agp on
// (R20) bit 2: 66Mhz, else 33Mhz
// (R21) bit 1: 64K window, else 32K
// (R22) bit 0: fast devsel, else medium
// (R23) strap word constant until next reset
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module brasc_top #(
    parameter int ACC_CYC = brasc_pkg::ROM_ACC_CYC
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic HOST_REQ,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_ADDR,
    input wire logic [3:0] HOST_BE,
    input wire logic [31:0] HOST_WDATA,
    output logic HOST_HIT,
    output logic HOST_ACK,
    output logic [31:0] HOST_RDATA,
    output logic [15:0] ROM_ADDR,
    input wire logic [7:0] ROM_DATA_I,
    output logic [7:0] ROM_DATA_O,
    output logic ROM_DATA_OE,
    output logic ROM_CE_N,
    output logic ROM_OE_N,
    output logic ROM_WE_N,
    input wire logic [7:0] VIDEO_PIXEL_I,
    output logic [7:0] VIDEO_PORT_O,
    output logic [7:0] TV_OUT_O,
    input wire logic [11:0] STRAP_PINS_I,
    output logic [31:0] SUBSYS_ID,
    output logic PLL_BYPASS,
    output logic MEM_SDRAM,
    output logic MEM_SHORT_PON,
    output logic IDSEL_REMAP,
    output logic IRQ_REG_DISABLE,
    output logic MEM_16MB_PARTS,
    output logic MEM_EIGHT_PARTS,
    output logic CLASS_MULTIMEDIA,
    output logic AGP_ENABLE,
    output logic BUS_66MHZ,
    output logic ROM_64K,
    output logic FAST_DEVSEL
);
    // ==========
    // state
    brasc_pkg::brasc_state_t state_ff, nxt_state;
    logic [31:0] rom_window_base_ff, misc_setup_one_ff, subsys_ff, wdata_ff, rdata_ff;
    logic [11:0] power_on_strap_word_ff;
    logic [3:0] mask_ff;
    logic [1:0] idx_ff, pick_idx;
    logic [15:0] base_addr_ff, byte_addr;
    logic [7:0] cnt_ff;
    logic loaded_ff, boot_job_ff, wr_job_ff, ack_ff, rom_64k, win_match, wr_allowed;
    // ==========
    // window decode
    assign rom_64k = power_on_strap_word_ff[brasc_pkg::STRAP_ROM_64K]; // see (R1) see (R21)
    assign win_match = rom_64k
        ? HOST_ADDR[31:brasc_pkg::BASE_LSB_64K] == rom_window_base_ff[31:brasc_pkg::BASE_LSB_64K]
        : HOST_ADDR[31:brasc_pkg::BASE_LSB_32K] == rom_window_base_ff[31:brasc_pkg::BASE_LSB_32K];
    // writes need both enables
    assign wr_allowed = rom_window_base_ff[brasc_pkg::ROM_EN_BIT]
        & misc_setup_one_ff[brasc_pkg::ROM_WR_EN_BIT]; // see (R8)
    assign HOST_HIT = rom_window_base_ff[brasc_pkg::ROM_EN_BIT] & win_match
        & (~HOST_WR | wr_allowed); // see (R4) see (R8)

    // lowest enabled byte goes first
    always_comb begin
        pick_idx = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (mask_ff[i]) begin
                pick_idx = i[1:0];
            end
        end
    end
    assign byte_addr = {base_addr_ff[15:2], idx_ff};
    // ==========
    // sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            brasc_pkg::ST_CAPT: nxt_state = brasc_pkg::ST_PICK;
            brasc_pkg::ST_PICK: begin
                if (mask_ff != 4'h0) begin
                    nxt_state = brasc_pkg::ST_CYC;
                end else if (boot_job_ff) begin
                    nxt_state = brasc_pkg::ST_IDLE;
                end else begin
                    nxt_state = brasc_pkg::ST_ACK;
                end
            end
            brasc_pkg::ST_CYC: begin
                if (cnt_ff == 8'h01) begin
                    nxt_state = brasc_pkg::ST_PICK;
                end
            end
            brasc_pkg::ST_IDLE: begin
                if (HOST_REQ & HOST_HIT) begin
                    nxt_state = brasc_pkg::ST_PICK;
                end
            end
            brasc_pkg::ST_ACK: nxt_state = brasc_pkg::ST_IDLE;
            default: nxt_state = brasc_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_ff <= brasc_pkg::ST_CAPT;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // straps caught once after release
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            power_on_strap_word_ff <= brasc_pkg::STRAP_RST;
        end else if (state_ff == brasc_pkg::ST_CAPT) begin
            power_on_strap_word_ff <= STRAP_PINS_I; // see (R10) see (R23)
        end
    end
    // job setup
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            boot_job_ff <= 1'b1;
            wr_job_ff <= 1'b0;
            mask_ff <= 4'h0;
            base_addr_ff <= 16'h0000;
            wdata_ff <= 32'h0000_0000;
        end else begin
            case (state_ff)
                brasc_pkg::ST_CAPT: begin
                    // id word sits just below the checksum word
                    mask_ff <= 4'hF; // see (R2) see (R3)
                    base_addr_ff <= STRAP_PINS_I[brasc_pkg::STRAP_ROM_64K]
                        ? brasc_pkg::ID_OFS_64K : brasc_pkg::ID_OFS_32K; // see (R1)
                end
                brasc_pkg::ST_IDLE: begin
                    boot_job_ff <= 1'b0;
                    if (HOST_REQ & HOST_HIT) begin
                        wr_job_ff <= HOST_WR;
                        mask_ff <= HOST_BE; // see (R5)
                        base_addr_ff <= {rom_64k & HOST_ADDR[15], HOST_ADDR[14:0]};
                        wdata_ff <= HOST_WDATA;
                    end
                end
                brasc_pkg::ST_CYC: begin
                    if (cnt_ff == 8'h01) begin
                        mask_ff[idx_ff] <= 1'b0; // see (R5)
                    end
                end
                default: ;
            endcase
        end
    end
    // one byte per rom cycle, so more enables take longer
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            idx_ff <= 2'd0;
            cnt_ff <= 8'h00;
        end else if (state_ff == brasc_pkg::ST_PICK) begin
            idx_ff <= pick_idx;
            cnt_ff <= 8'(ACC_CYC); // see (R5)
        end else if (state_ff == brasc_pkg::ST_CYC) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
    // byte capture
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_ff <= 32'h0000_0000;
            subsys_ff <= 32'h0000_0000;
            loaded_ff <= 1'b0;
        end else begin
            if (state_ff == brasc_pkg::ST_IDLE && HOST_REQ && HOST_HIT && !HOST_WR) begin
                rdata_ff <= 32'h0000_0000;
            end
            if (state_ff == brasc_pkg::ST_CYC && cnt_ff == 8'h01 && !wr_job_ff) begin
                if (boot_job_ff) begin
                    subsys_ff[idx_ff*8 +: 8] <= ROM_DATA_I; // see (R2)
                end else begin
                    rdata_ff[idx_ff*8 +: 8] <= ROM_DATA_I; // see (R4)
                end
            end
            if (state_ff == brasc_pkg::ST_PICK && boot_job_ff && mask_ff == 4'h0) begin
                loaded_ff <= 1'b1;
            end
        end
    end
    assign HOST_ACK = ack_ff;
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (state_ff == brasc_pkg::ST_PICK) && !boot_job_ff && mask_ff == 4'h0;
        end
    end
    assign HOST_RDATA = rdata_ff;
    assign SUBSYS_ID = subsys_ff;
    // ==========
    // rom pins and shared video/tv outputs
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ROM_ADDR <= 16'h0000;
            ROM_DATA_O <= 8'h00;
            ROM_DATA_OE <= 1'b0;
            ROM_CE_N <= 1'b1;
            ROM_OE_N <= 1'b1;
            ROM_WE_N <= 1'b1;
        end else begin
            ROM_ADDR <= byte_addr;
            ROM_DATA_O <= wdata_ff[idx_ff*8 +: 8];
            ROM_CE_N <= nxt_state != brasc_pkg::ST_CYC;
            ROM_OE_N <= !(nxt_state == brasc_pkg::ST_CYC && !wr_job_ff);
            // strobe ends early so data holds past it
            ROM_WE_N <= !(state_ff == brasc_pkg::ST_CYC && wr_job_ff && cnt_ff > 8'h02); // see (R8)
            ROM_DATA_OE <= nxt_state == brasc_pkg::ST_CYC && wr_job_ff;
        end
    end
    // shared pins carry rom traffic during a cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            VIDEO_PORT_O <= 8'h00;
            TV_OUT_O <= 8'h00;
        end else if (state_ff == brasc_pkg::ST_CYC) begin
            VIDEO_PORT_O <= wr_job_ff ? ROM_DATA_O : ROM_DATA_I; // see (R6)
            TV_OUT_O <= wr_job_ff ? ROM_DATA_O : ROM_DATA_I; // see (R6)
        end else begin
            VIDEO_PORT_O <= VIDEO_PIXEL_I;
            TV_OUT_O <= VIDEO_PIXEL_I;
        end
    end
    // ==========
    // strap decode
    assign PLL_BYPASS = power_on_strap_word_ff[brasc_pkg::STRAP_PLL_BYPASS]; // see (R11)
    assign MEM_SDRAM = power_on_strap_word_ff[brasc_pkg::STRAP_SDRAM]; // see (R12)
    assign MEM_SHORT_PON = power_on_strap_word_ff[brasc_pkg::STRAP_SHORT_PON]; // see (R13)
    assign IDSEL_REMAP = power_on_strap_word_ff[brasc_pkg::STRAP_IDSEL_REMAP]; // see (R14)
    assign IRQ_REG_DISABLE = power_on_strap_word_ff[brasc_pkg::STRAP_IRQ_DIS]; // see (R15)
    assign MEM_16MB_PARTS = power_on_strap_word_ff[brasc_pkg::STRAP_DENSITY]; // see (R16)
    assign MEM_EIGHT_PARTS = power_on_strap_word_ff[brasc_pkg::STRAP_EIGHT_PARTS]; // see (R17)
    assign CLASS_MULTIMEDIA = power_on_strap_word_ff[brasc_pkg::STRAP_MULTIMEDIA]; // see (R18)
    assign AGP_ENABLE = power_on_strap_word_ff[brasc_pkg::STRAP_AGP_EN]; // see (R19)
    assign BUS_66MHZ = power_on_strap_word_ff[brasc_pkg::STRAP_66MHZ]; // see (R20)
    assign ROM_64K = rom_64k; // see (R21)
    assign FAST_DEVSEL = power_on_strap_word_ff[brasc_pkg::STRAP_FAST_DEVSEL]; // see (R22)
    // ==========
    // axi4-lite write channel
    logic aw_take;
    assign aw_take = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
    assign S_AXI_AWREADY = aw_take;
    assign S_AXI_WREADY = aw_take;
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rom_window_base_ff <= brasc_pkg::ROM_BASE_RST;
            misc_setup_one_ff <= brasc_pkg::MISC_RST;
        end else if (aw_take) begin
            if (S_AXI_AWADDR == brasc_pkg::ADDR_ROM_BASE) begin
                rom_window_base_ff <= merge(rom_window_base_ff, S_AXI_WDATA, S_AXI_WSTRB)
                    & brasc_pkg::BASE_MASK_32K; // see (R4)
            end
            if (S_AXI_AWADDR == brasc_pkg::ADDR_MISC) begin
                misc_setup_one_ff <= merge(misc_setup_one_ff, S_AXI_WDATA, S_AXI_WSTRB); // see (R8)
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= brasc_pkg::RESP_OKAY;
        end else if (aw_take) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (S_AXI_AWADDR == brasc_pkg::ADDR_ROM_BASE
                || S_AXI_AWADDR == brasc_pkg::ADDR_MISC) ? brasc_pkg::RESP_OKAY
                : brasc_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end
    // ==========
    // axi4-lite read channel
    logic ar_take, rd_ok;
    logic [31:0] rd_mux;
    assign ar_take = S_AXI_ARVALID & ~S_AXI_RVALID;
    assign S_AXI_ARREADY = ar_take;

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (S_AXI_ARADDR)
            brasc_pkg::ADDR_ROM_BASE: rd_mux = rom_window_base_ff;
            brasc_pkg::ADDR_MISC: rd_mux = misc_setup_one_ff;
            brasc_pkg::ADDR_STRAP: rd_mux = {20'h0_0000, power_on_strap_word_ff}; // see (R10)
            brasc_pkg::ADDR_SUBSYS: rd_mux = subsys_ff;
            brasc_pkg::ADDR_STATUS: begin
                rd_mux[brasc_pkg::STATUS_LOADED] = loaded_ff;
                rd_mux[brasc_pkg::STATUS_ACTIVE] = state_ff == brasc_pkg::ST_CYC;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= brasc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_ok ? brasc_pkg::RESP_OKAY : brasc_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
endmodule
